// File: sps_regs.svh
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ****************************************
// Control port field positions
// ****************************************
`define SPS_CTL_MODE_HI  3
`define SPS_CTL_MODE_LO  0
`define SPS_CTL_ENABLE   5

// ****************************************
// Status port field positions
// ****************************************
`define SPS_ST_FULL      0
`define SPS_ST_UPD       1
`define SPS_ST_RW        2
`define SPS_ST_START     3
`define SPS_ST_STOP      4

// ****************************************
// Mode codes
// ****************************************
`define SPS_MODE_7B      4'h6
`define SPS_MODE_10B     4'h7
`define SPS_MODE_7B_SS   4'he
`define SPS_MODE_10B_SS  4'hf
`define SPS_MODE_SS_ONLY 4'hb

// ****************************************
// Protocol constants
// ****************************************
`define SPS_HI_PREFIX    5'h1e
`define SPS_BITS         4'h8
`define SPS_LAST_TX_BIT  4'h7

// ****************************************
// Event channels, link to core
// ****************************************
`define SPS_EV_ACC       0
`define SPS_EV_REF       1
`define SPS_EV_START     2
`define SPS_EV_STOP      3
`define SPS_EV_TXD       4
`define SPS_EV_N         5

`endif

// File: sps_pkg.sv
package sps_pkg;
   typedef enum logic [2:0] {
      LS_IDLE, LS_RX, LS_ACK, LS_NACK, LS_HOLD, LS_TX, LS_TACK
   } sps_lstate_t;

   typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_DATA} sps_phase_t;

   typedef struct packed {
      logic        scl_p;
      logic        sda_p;
      sps_lstate_t st;
      sps_phase_t  ph;
      logic [3:0]  cnt;
      logic [7:0]  sr;
      logic [7:0]  tx;
      logic [7:0]  byte_v;
      logic        tag_update;
      logic        tag_addr;
      logic        tag_rw;
      logic        hi_ok;
      logic        hold_hi;
      logic        tx_mode;
      logic        go_hold;
      logic        sda_low;
      logic        scl_low;
      logic [4:0]  ev;
   } sps_link_t;

   typedef struct packed {
      logic [7:0] rxbuf;
      logic [7:0] tx;
      logic       buffer_full;
      logic       ov;
      logic       update_address;
      logic       rw;
      logic       s;
      logic       p;
      logic       irq;
   } sps_core_t;
endpackage

// File: sps_sync.sv
`timescale 1ns/1ps
module sps_sync #(
   parameter int W = 1
) (
   // Destination clock
   input  wire logic         clk_i,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // No reset: the pair settles within two edges of any input
   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
   end

   assign q_o = sync_q;
endmodule

// File: sps_pulse_x.sv
`timescale 1ns/1ps
module sps_pulse_x (
   // Source side
   input  wire logic src_clk_i,
   input  wire logic src_nrst_i,
   input  wire logic src_pulse_i,
   // Destination side
   input  wire logic dst_clk_i,
   input  wire logic dst_nrst_i,
   output logic      dst_pulse_o
);
   logic tog_q;
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge src_clk_i) begin
      if (!src_nrst_i) begin
         tog_q <= 1'b0;
      end else if (src_pulse_i) begin
         tog_q <= ~tog_q;
      end
   end

   always_ff @(posedge dst_clk_i) begin
      if (!dst_nrst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= tog_q;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Pulses must be spaced by several destination cycles
   assign dst_pulse_o = sync_q ^ last_q;
endmodule

// File: sps_i2c_slave.sv
`timescale 1ns/1ps
`include "sps_regs.svh"
// Functional notes
// - Standard-speed slave, 7/10-bit, no general call
// - Everything active only while enabled
// - Mode field picks slave and start/stop modes
// - Start/stop set interrupt in those modes
// - Pins open-drain when enabled, direction input
// - Slave transmitter drives data line itself
// - Matched byte acknowledged, then buffer loaded
// - Full or overflow: no ack, no load
// - Buffer read clears full; overflow software cleared
// - Wait start, shift eight bits on rise
// - Address compare at eighth falling edge
// - Match sets buffer, full, ack, interrupt
// - First 10-bit byte is 11110, A9 A8, 0
// - High byte sets update flag, stretches clock
// - Low byte sets update again, rewrite releases
// - Read after restart: high byte loads buffer, sets full and interrupt, no update flag
// - Direction bit reported in status, address buffered
module sps_i2c_slave
   import sps_pkg::*;
(
   // Clocks and reset
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       link_clk_i,
   // Software control
   input  wire logic [7:0] port_control_i,
   input  wire logic [7:0] own_address_i,
   input  wire logic       addr_wr_i,
   input  wire logic       buf_rd_i,
   input  wire logic       buf_wr_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       ovf_clr_i,
   input  wire logic       irq_clr_i,
   input  wire logic       dir_scl_in_i,
   input  wire logic       dir_sda_in_i,
   // Software status
   output logic      [7:0] rx_buffer_o,
   output logic      [7:0] port_status_o,
   output logic            receive_overflow_o,
   output logic            port_irq_flag_o,
   // Bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o
);
   // ****************************************
   // Mode decode
   // ****************************************
   function automatic logic is_slave(input logic [3:0] m);
      return m == `SPS_MODE_7B || m == `SPS_MODE_10B ||
             m == `SPS_MODE_7B_SS || m == `SPS_MODE_10B_SS;
   endfunction

   function automatic logic is_ss(input logic [3:0] m);
      return m == `SPS_MODE_7B_SS || m == `SPS_MODE_10B_SS ||
             m == `SPS_MODE_SS_ONLY;
   endfunction

   function automatic logic is_ten(input logic [3:0] m);
      return m == `SPS_MODE_10B || m == `SPS_MODE_10B_SS;
   endfunction

   sps_link_t l_q, l_d;
   sps_core_t c_q, c_d;
   logic      lrst_n;
   logic [`SPS_EV_N-1:0] ev_c;

   // ****************************************
   // Crossings into the link domain
   // ****************************************
   // Control words are quasi-static: change them only while idle
   logic       scl_s, sda_s, en_s, busy_s, update_s, dscl_s, dsda_s;
   logic [3:0] mode_s;
   logic [7:0] own_s, tx_s;

   sps_sync #(.W(1)) u_rst_sync (
      .clk_i (link_clk_i),
      .d_i   (nrst_i),
      .q_o   (lrst_n)
   );

   sps_sync #(.W(27)) u_lvl_sync (
      .clk_i (link_clk_i),
      .d_i   ({scl_i, sda_i, port_control_i[`SPS_CTL_ENABLE],
               port_control_i[`SPS_CTL_MODE_HI:`SPS_CTL_MODE_LO],
               own_address_i, c_q.buffer_full | c_q.ov,
               c_q.update_address,
               dir_scl_in_i, dir_sda_in_i, c_q.tx}),
      .q_o   ({scl_s, sda_s, en_s, mode_s, own_s, busy_s, update_s,
               dscl_s, dsda_s, tx_s})
   );

   // ****************************************
   // Link engine
   // ****************************************
   logic rise, fall, start, stop, match;

   always_comb begin
      l_d    = l_q;
      l_d.ev = '0;
      l_d.scl_p = scl_s;
      l_d.sda_p = sda_s;
      rise   = scl_s & ~l_q.scl_p;
      fall   = ~scl_s & l_q.scl_p;
      start  = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
      stop   = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;
      // own address only, no general call
      case (l_q.ph)
         PH_FIRST: begin
            if (is_ten(mode_s)) begin
               match = l_q.sr[7:3] == `SPS_HI_PREFIX &&
                       l_q.sr[2:1] == own_s[2:1] &&
                       (!l_q.sr[0] || l_q.hi_ok);
            end else begin
               match = l_q.sr[7:1] == own_s[7:1];
            end
         end
         PH_SECOND: match = l_q.sr == own_s;
         default:   match = 1'b1;
      endcase
      if (!en_s) begin
         l_d.st      = LS_IDLE;
         l_d.sda_low = 1'b0;
         l_d.scl_low = 1'b0;
         l_d.hi_ok   = 1'b0;
      end else if (start) begin
         l_d.ev[`SPS_EV_START] = is_ss(mode_s);
         if (is_slave(mode_s)) begin
            l_d.st      = LS_RX;
            l_d.cnt     = '0;
            l_d.ph      = PH_FIRST;
            l_d.sda_low = 1'b0;
            l_d.scl_low = 1'b0;
         end
      end else if (stop) begin
         l_d.ev[`SPS_EV_STOP] = is_ss(mode_s);
         l_d.st      = LS_IDLE;
         l_d.sda_low = 1'b0;
         l_d.scl_low = 1'b0;
         l_d.hi_ok   = 1'b0;
      end else begin
         case (l_q.st)
            LS_RX: begin
               if (rise) begin
                  l_d.sr  = {l_q.sr[6:0], sda_s};
                  l_d.cnt = l_q.cnt + 4'h1;
               end
               if (fall && l_q.cnt == `SPS_BITS) begin
                  if (!match) begin
                     l_d.st    = LS_IDLE;
                     l_d.hi_ok = 1'b0;
                  end else begin
                     l_d.byte_v   = l_q.sr;
                     l_d.tag_addr = l_q.ph != PH_DATA;
                     l_d.tag_rw   = l_q.ph == PH_FIRST && l_q.sr[0];
                     // read restart: no update flag, no hold
                     l_d.tag_update = is_ten(mode_s) && l_q.ph != PH_DATA &&
                                      !(l_q.ph == PH_FIRST && l_q.sr[0]);
                     l_d.go_hold  = l_d.tag_update;
                     l_d.tx_mode  = l_q.ph == PH_FIRST && l_q.sr[0];
                     if (l_q.ph == PH_FIRST && is_ten(mode_s) &&
                         !l_q.sr[0]) begin
                        l_d.ph = PH_SECOND;
                     end else begin
                        l_d.ph = PH_DATA;
                     end
                     if (l_q.ph == PH_SECOND) begin
                        l_d.hi_ok = 1'b1;
                     end
                     if (busy_s) begin
                        l_d.st = LS_NACK;
                     end else begin
                        l_d.st      = LS_ACK;
                        l_d.sda_low = 1'b1;
                     end
                  end
               end
            end
            LS_ACK: begin
               if (fall) begin
                  // load and flag on ninth fall
                  l_d.sda_low = 1'b0;
                  l_d.ev[`SPS_EV_ACC] = 1'b1;
                  l_d.cnt = '0;
                  if (l_q.go_hold) begin
                     l_d.st      = LS_HOLD;
                     l_d.scl_low = 1'b1;
                     l_d.hold_hi = 1'b0;
                  end else if (l_q.tx_mode) begin
                     l_d.st      = LS_TX;
                     l_d.tx      = tx_s;
                     l_d.sda_low = ~tx_s[7];
                  end else begin
                     l_d.st = LS_RX;
                  end
               end
            end
            LS_NACK: begin
               if (fall) begin
                  l_d.ev[`SPS_EV_REF] = 1'b1;
                  l_d.cnt = '0;
                  l_d.st  = l_q.tag_addr ? LS_IDLE : LS_RX;
               end
            end
            LS_HOLD: begin
               if (update_s) begin
                  l_d.hold_hi = 1'b1;
               end
               if (l_q.hold_hi && !update_s) begin
                  l_d.scl_low = 1'b0;
                  l_d.st      = LS_RX;
               end
            end
            LS_TX: begin
               if (fall) begin
                  l_d.cnt = l_q.cnt + 4'h1;
                  if (l_q.cnt == `SPS_LAST_TX_BIT) begin
                     l_d.sda_low = 1'b0;
                     l_d.st      = LS_TACK;
                  end else begin
                     l_d.tx      = {l_q.tx[6:0], 1'b0};
                     l_d.sda_low = ~l_q.tx[6];
                  end
               end
            end
            LS_TACK: begin
               if (rise) begin
                  l_d.ev[`SPS_EV_TXD] = 1'b1;
                  l_d.st = sda_s ? LS_IDLE : LS_TACK;
               end else if (fall) begin
                  l_d.st      = LS_TX;
                  l_d.cnt     = '0;
                  l_d.tx      = tx_s;
                  l_d.sda_low = ~tx_s[7];
               end
            end
            default: l_d.st = LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (!lrst_n) begin
         l_q       <= '0;
         // Idle-high line history: no false edge after reset
         l_q.scl_p <= 1'b1;
         l_q.sda_p <= 1'b1;
      end else begin
         l_q <= l_d;
      end
   end

   // open drain, only with pins set as inputs
   assign sda_oe_o = l_q.sda_low & en_s & dsda_s;
   assign scl_oe_o = l_q.scl_low & en_s & dscl_s;
   assign sda_o    = 1'b0;
   assign scl_o    = 1'b0;

   // ****************************************
   // Events into the core domain
   // ****************************************
   generate
      for (genvar i = 0; i < `SPS_EV_N; i++) begin : g_ev
         sps_pulse_x u_ev (
            .src_clk_i   (link_clk_i),
            .src_nrst_i  (lrst_n),
            .src_pulse_i (l_q.ev[i]),
            .dst_clk_i   (core_clk_i),
            .dst_nrst_i  (nrst_i),
            .dst_pulse_o (ev_c[i])
         );
      end
   endgenerate

   // ****************************************
   // Software-facing state
   // ****************************************
   logic ss_c;

   always_comb begin
      c_d  = c_q;
      ss_c = is_ss(port_control_i[`SPS_CTL_MODE_HI:`SPS_CTL_MODE_LO]);
      // Clears first so that a same-cycle set wins
      // read clears full, ovf_clr_i clears overflow
      if (buf_rd_i)  c_d.buffer_full = 1'b0;
      if (ovf_clr_i) c_d.ov  = 1'b0;
      if (irq_clr_i) c_d.irq = 1'b0;
      if (addr_wr_i) c_d.update_address = 1'b0;
      if (buf_wr_i)  c_d.tx  = tx_data_i;
      // Byte fields are stable here: link holds them until next byte
      if (ev_c[`SPS_EV_ACC]) begin
         c_d.rxbuf = l_q.byte_v;
         c_d.buffer_full = 1'b1;
         c_d.irq   = 1'b1;
         if (l_q.tag_update) c_d.update_address = 1'b1;
         if (l_q.tag_addr) c_d.rw = l_q.tag_rw;
      end
      if (ev_c[`SPS_EV_REF]) begin
         c_d.irq = 1'b1;
         if (c_q.buffer_full) c_d.ov = 1'b1;
      end
      if (ev_c[`SPS_EV_TXD]) c_d.irq = 1'b1;
      if (ev_c[`SPS_EV_START]) begin
         c_d.s = 1'b1;
         c_d.p = 1'b0;
         if (ss_c) c_d.irq = 1'b1;
      end
      if (ev_c[`SPS_EV_STOP]) begin
         c_d.p = 1'b1;
         c_d.s = 1'b0;
         if (ss_c) c_d.irq = 1'b1;
      end
      if (!port_control_i[`SPS_CTL_ENABLE]) begin
         c_d.s = 1'b0;
         c_d.p = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign rx_buffer_o        = c_q.rxbuf;
   assign receive_overflow_o = c_q.ov;
   assign port_irq_flag_o    = c_q.irq;
   always_comb begin
      port_status_o                = '0;
      port_status_o[`SPS_ST_FULL]  = c_q.buffer_full;
      port_status_o[`SPS_ST_UPD]   = c_q.update_address;
      port_status_o[`SPS_ST_RW]    = c_q.rw;
      port_status_o[`SPS_ST_START] = c_q.s;
      port_status_o[`SPS_ST_STOP]  = c_q.p;
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence seq_accept;
      ev_c[`SPS_EV_ACC] ##1 (port_irq_flag_o && c_q.buffer_full);
   endsequence
   sequence seq_decide;
      l_q.st == LS_RX && fall && l_q.cnt == `SPS_BITS && match;
   endsequence

   enable_gate_a: assert property (@(posedge link_clk_i)
      disable iff (!lrst_n) !en_s |=> !sda_oe_o && !scl_oe_o)
      else $error("pins driven while disabled");
   refuse_noack_a: assert property (@(posedge link_clk_i)
      disable iff (!lrst_n) (seq_decide and busy_s) |=> !l_q.sda_low)
      else $error("ack driven while busy");
   ack_drive_a: assert property (@(posedge link_clk_i)
      disable iff (!lrst_n) (seq_decide and !busy_s && en_s && !start
      && !stop) |=> l_q.st == LS_ACK && l_q.sda_low)
      else $error("no ack after match");
   stretch_hold_a: assert property (@(posedge link_clk_i)
      disable iff (!lrst_n) l_q.st == LS_HOLD |-> l_q.scl_low)
      else $error("clock released while holding");
   stop_idle_a: assert property (@(posedge link_clk_i)
      disable iff (!lrst_n) (stop && en_s) |=> l_q.st == LS_IDLE
      && !l_q.sda_low && !l_q.scl_low)
      else $error("stop did not release");
   irq_set_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) ev_c[`SPS_EV_ACC] |-> seq_accept)
      else $error("accepted byte not flagged");
   buf_load_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) ev_c[`SPS_EV_ACC] |=>
      rx_buffer_o == $past(l_q.byte_v))
      else $error("buffer not loaded");
   full_clear_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) buf_rd_i && !ev_c[`SPS_EV_ACC] |=>
      !c_q.buffer_full)
      else $error("read did not clear full");
   ovf_hold_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) c_q.ov && !ovf_clr_i |=> c_q.ov)
      else $error("overflow cleared by itself");
   ovf_set_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) ev_c[`SPS_EV_REF] && c_q.buffer_full |=> c_q.ov
      && port_irq_flag_o)
      else $error("overflow not set");
   ss_irq_a: assert property (@(posedge core_clk_i)
      disable iff (!nrst_i) ev_c[`SPS_EV_START] && ss_c |=>
      port_irq_flag_o && c_q.s)
      else $error("start not flagged");
endmodule

// File: sps_bus_master.sv
`timescale 1ns/1ps
// ****************************************
// Behavioural two-wire bus master
// ****************************************
module sps_bus_master (
   // Resolved bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // Open-drain pulls, high pulls line low
   output logic      scl_low_o,
   output logic      sda_low_o,
   // Clock held low past the bound
   output logic      stuck_o
);
   localparam int HALF = 800;

   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
      stuck_o   = 1'b0;
   end

   // Also serves as repeated start
   task automatic start();
      sda_low_o = 1'b0;
      #HALF scl_low_o = 1'b0;
      #HALF sda_low_o = 1'b1;
      #HALF scl_low_o = 1'b1;
      #HALF;
   endtask

   task automatic xfer(input logic b, output logic r);
      int n;
      n = 0;
      sda_low_o = ~b;
      #HALF scl_low_o = 1'b0;
      // Bounded wait: slave may stretch
      while (scl_i !== 1'b1 && n < 4000) begin
         #50 n++;
      end
      if (n == 4000) stuck_o = 1'b1;
      #HALF r = sda_i;
      scl_low_o = 1'b1;
      #HALF;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(~ack, r);
   endtask

   task automatic stop();
      sda_low_o = 1'b1;
      #HALF scl_low_o = 1'b0;
      #HALF sda_low_o = 1'b0;
      #HALF;
   endtask
endmodule

// File: sps_i2c_slave_tb.sv
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_i2c_slave_tb;
   logic       core_clk;
   logic       link_clk;
   logic       nrst;
   logic [7:0] ctl;
   logic [7:0] own;
   logic [7:0] txd;
   logic [4:0] pl;
   logic       dir_scl;
   logic       dir_sda;
   logic [7:0] rxb;
   logic [7:0] st;
   logic       ovf;
   logic       irq;
   logic       scl_oe;
   logic       sda_oe;
   logic       m_scl;
   logic       m_sda;
   logic       stuck;
   logic       scl_lvl;
   logic       sda_lvl;
   int         fail_count;
   int         cmp_count;
   wire        scl = ~(m_scl | scl_oe);
   wire        sda = ~(m_sda | sda_oe);

   sps_i2c_slave DUT (
      .core_clk_i         (core_clk),
      .nrst_i             (nrst),
      .link_clk_i         (link_clk),
      .port_control_i     (ctl),
      .own_address_i      (own),
      .addr_wr_i          (pl[3]),
      .buf_rd_i           (pl[0]),
      .buf_wr_i           (pl[4]),
      .tx_data_i          (txd),
      .ovf_clr_i          (pl[1]),
      .irq_clr_i          (pl[2]),
      .dir_scl_in_i       (dir_scl),
      .dir_sda_in_i       (dir_sda),
      .rx_buffer_o        (rxb),
      .port_status_o      (st),
      .receive_overflow_o (ovf),
      .port_irq_flag_o    (irq),
      .scl_i              (scl),
      .scl_o              (scl_lvl),
      .scl_oe_o           (scl_oe),
      .sda_i              (sda),
      .sda_o              (sda_lvl),
      .sda_oe_o           (sda_oe)
   );

   sps_bus_master m (
      .scl_i     (scl),
      .sda_i     (sda),
      .scl_low_o (m_scl),
      .sda_low_o (m_sda),
      .stuck_o   (stuck)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Link clock, unrelated phase
   initial begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge stuck) begin
      fail_count++;
      end_of_test();
   end

   task automatic chk(input string nm, input logic [7:0] s,
                      input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask

   // software clears the flag after every byte but the 10-bit read address byte
   // 0 read, 1 ovf clear, 2 irq clear, 3 addr write, 4 tx load
   task automatic pulse(input int k);
      tick(1);
      pl[k] = 1'b1;
      tick(1);
      pl = '0;
      tick(1);
   endtask

   task automatic t_write7();
      logic ack;
      tick(1);
      ctl = {4'h2, `SPS_MODE_7B};
      own = 8'ha4;
      tick(10);
      m.start();
      tick(20);
      chk("irq no ss", irq, 8'h00);
      m.wbyte(8'ha4, ack);
      chk("addr ack", ack, 8'h01);
      chk("addr buf", rxb, 8'ha4);
      chk("addr st", st & 8'h07, 8'h01);
      chk("addr irq", irq, 8'h01);
      pulse(0);
      pulse(2);
      chk("full clr", st & 8'h07, 8'h00);
      m.wbyte(8'h5a, ack);
      chk("data ack", ack, 8'h01);
      chk("data buf", rxb, 8'h5a);
      pulse(2);
      m.wbyte(8'h33, ack);
      chk("full nack", ack, 8'h00);
      chk("full buf", rxb, 8'h5a);
      chk("full irq", irq, 8'h01);
      chk("ovf set", ovf, 8'h01);
      m.stop();
      pulse(0);
      pulse(2);
      chk("ovf kept", ovf, 8'h01);
      m.start();
      m.wbyte(8'ha4, ack);
      m.stop();
      chk("ovf nack", ack, 8'h00);
      pulse(1);
      chk("ovf clr", ovf, 8'h00);
      pulse(2);
   endtask

   task automatic t_refuse();
      logic ack;
      for (int k = 0; k < 3; k++) begin
         tick(1);
         ctl = (k == 1) ? {4'h0, `SPS_MODE_7B} : {4'h2, `SPS_MODE_7B};
         own = (k == 0) ? 8'h10 : 8'ha4;
         dir_sda = (k != 2);
         tick(10);
         m.start();
         m.wbyte(8'ha4, ack);
         m.stop();
         chk("refuse ack", ack, 8'h00);
         if (k < 2) chk("refuse irq", irq, 8'h00);
         pulse(0);
         pulse(2);
      end
      dir_sda = 1'b1;
   endtask

   task automatic t_ten();
      logic       ack;
      logic [7:0] d;
      tick(1);
      ctl = {4'h2, `SPS_MODE_10B};
      own = 8'hf2;
      tick(10);
      m.start();
      m.wbyte(8'hf2, ack);
      tick(4);
      chk("hi ack", ack, 8'h01);
      chk("hi hold", scl_oe, 8'h01);
      chk("pin lvl", {6'h00, scl_lvl, sda_lvl}, 8'h00);
      chk("hi st", st & 8'h07, 8'h03);
      pulse(0);
      pulse(2);
      own = 8'h34;
      pulse(3);
      chk("ua clr", st & 8'h07, 8'h00);
      m.wbyte(8'h34, ack);
      tick(4);
      chk("lo ack", ack, 8'h01);
      chk("lo hold", scl_oe, 8'h01);
      chk("lo st", st & 8'h07, 8'h03);
      chk("lo buf", rxb, 8'h34);
      pulse(0);
      pulse(2);
      own = 8'hf2;
      pulse(3);
      m.wbyte(8'h77, ack);
      chk("d10 ack", ack, 8'h01);
      chk("d10 buf", rxb, 8'h77);
      pulse(0);
      pulse(2);
      txd = 8'hc3;
      pulse(4);
      m.start();
      m.wbyte(8'hf3, ack);
      chk("rd ack", ack, 8'h01);
      chk("rd st", st & 8'h07, 8'h05);
      m.rbyte(1'b0, d);
      chk("tx data", d, 8'hc3);
      m.stop();
      pulse(0);
      pulse(2);
   endtask

   task automatic t_ss();
      logic [3:0] md [3];
      md = '{`SPS_MODE_7B_SS, `SPS_MODE_10B_SS, `SPS_MODE_SS_ONLY};
      for (int k = 0; k < 3; k++) begin
         tick(1);
         ctl = {4'h2, md[k]};
         tick(10);
         m.start();
         tick(10);
         chk("start irq", irq, 8'h01);
         chk("start st", st[3], 8'h01);
         pulse(2);
         m.stop();
         tick(20);
         chk("stop irq", irq, 8'h01);
         chk("stop st", st[4], 8'h01);
         pulse(2);
      end
   endtask

   initial begin
      nrst = 1'b0;
      ctl = 8'h00;
      own = 8'h00;
      txd = 8'h00;
      pl = '0;
      dir_scl = 1'b1;
      dir_sda = 1'b1;
      fail_count = 0;
      cmp_count = 0;
      // Long enough for the link side too
      repeat (6) @(posedge core_clk);
      #2 nrst = 1'b1;
      tick(10);
      t_write7();
      t_refuse();
      t_ten();
      t_ss();
      end_of_test();
   end
endmodule
